// >>> sac_pkg.sv
`default_nettype none
package sac_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL_ONE   = 8'h0E;
    localparam logic [7:0] ADDR_CTRL_TWO   = 8'h0F;
    localparam logic [7:0] ADDR_RES_LOW    = 8'h20;
    localparam logic [7:0] ADDR_RES_HIGH   = 8'h21;

    localparam logic [7:0] CTRL_ONE_RESET  = 8'h10;
    localparam logic [5:0] CTRL_TWO_RESET  = 6'h10;

    localparam int         GO_BIT          = 7;
    localparam int         OP_LSB          = 5;
    localparam int         GATE_BIT        = 4;
    localparam int         CHAN_LSB        = 0;
    localparam int         LADDER_BIT      = 5;
    localparam int         ACK_LSB         = 1;

    localparam logic [1:0] OP_OFF          = 2'h0;
    localparam logic [1:0] OP_SINGLE       = 2'h1;
    localparam logic [1:0] OP_REPEAT       = 2'h3;

    localparam int         RES_W           = 10;
    localparam int         CNT_W           = 11;
    localparam int         NUM_CHAN        = 6;
    localparam int         SAMPLE_SLOTS    = 4;
    localparam int         SLOT_SHIFT      = 4;

    // ************************************************************
    // Conversion times in oscillator periods
    // ************************************************************
    localparam logic [10:0] T_CODE0        = 11'h027;
    localparam logic [10:0] T_CODE2        = 11'h04E;
    localparam logic [10:0] T_CODE3        = 11'h09C;
    localparam logic [10:0] T_CODE4        = 11'h138;
    localparam logic [10:0] T_CODE5        = 11'h270;
    localparam logic [10:0] T_CODE6        = 11'h4E0;

    typedef enum logic [1:0] {
        S_IDLE  = 2'h0,
        S_CONV  = 2'h1,
        S_STORE = 2'h3
    } sac_state_e;

    // Reserved codes fall back to the longest time, the safest choice
    function automatic logic [10:0] conv_periods(input logic [2:0] code);
        case (code)
            3'h0:    conv_periods = T_CODE0;
            3'h2:    conv_periods = T_CODE2;
            3'h3:    conv_periods = T_CODE3;
            3'h4:    conv_periods = T_CODE4;
            3'h5:    conv_periods = T_CODE5;
            default: conv_periods = T_CODE6;
        endcase
    endfunction : conv_periods

    function automatic logic [5:0] chan_onehot(input logic [3:0] code);
        chan_onehot = 6'h00;
        if (code < 4'h6) begin
            chan_onehot[code[2:0]] = 1'b1;
        end
    endfunction : chan_onehot

endpackage : sac_pkg
`default_nettype wire

// >>> sac_conv_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sac_conv_timer
    import sac_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       arst_n_i,
    // Control
    input  wire logic       start_i,
    input  wire logic       abort_i,
    input  wire logic [2:0] ack_i,
    // Phases
    output logic            sample_o,
    output logic            step_o,
    output logic            done_o
);

    logic             run_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] sub_reg;
    logic [3:0]       slot_reg;
    logic [CNT_W-1:0] total_reg;
    logic [CNT_W-1:0] slen_reg;
    wire              wrap_w = run_reg && (sub_reg == slen_reg - 11'h001);

    // Sixteen slots: four sample, ten bit trials, rest settle
    assign done_o   = run_reg && (cnt_reg == total_reg - 11'h001);
    assign sample_o = run_reg && (slot_reg < 4'(SAMPLE_SLOTS));
    assign step_o   = wrap_w && (slot_reg >= 4'(SAMPLE_SLOTS))
                    && (slot_reg < 4'(SAMPLE_SLOTS + RES_W));

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_reg   <= 1'b0;
            cnt_reg   <= 11'h000;
            sub_reg   <= 11'h000;
            slot_reg  <= 4'h0;
            total_reg <= 11'h000;
            slen_reg  <= 11'h000;
        end else if (abort_i) begin
            run_reg <= 1'b0;
        end else if (start_i) begin
            run_reg   <= 1'b1;
            cnt_reg   <= 11'h000;
            sub_reg   <= 11'h000;
            slot_reg  <= 4'h0;
            total_reg <= conv_periods(ack_i);
            slen_reg  <= conv_periods(ack_i) >> SLOT_SHIFT;
        end else if (run_reg) begin
            cnt_reg  <= cnt_reg + 11'h001;
            run_reg  <= !done_o;
            sub_reg  <= wrap_w ? 11'h000 : sub_reg + 11'h001;
            slot_reg <= wrap_w ? slot_reg + 4'h1 : slot_reg;
        end
    end

endmodule : sac_conv_timer
`default_nettype wire

// >>> sac_sar_core.sv
`timescale 1ns/1ps
`default_nettype none
module sac_sar_core
    import sac_pkg::*;
#(
    parameter int W = RES_W
) (
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         arst_n_i,
    // Search control
    input  wire logic         start_i,
    input  wire logic         step_i,
    input  wire logic         comp_i,
    // Trial code to the ladder, final after the last step
    output logic [W-1:0]      trial_o
);

    logic [W-1:0] trial_reg;
    logic [W-1:0] mask_reg;
    wire  [W-1:0] kept_w = comp_i ? trial_reg : (trial_reg & ~mask_reg);
    wire  [W-1:0] msb_w  = {1'b1, {(W-1){1'b0}}};

    assign trial_o = trial_reg;

    // Comparator high means input at or above trial: keep the bit
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trial_reg <= '0;
            mask_reg  <= '0;
        end else if (start_i) begin
            trial_reg <= msb_w;
            mask_reg  <= msb_w;
        end else if (step_i && (mask_reg != '0)) begin
            trial_reg <= kept_w | (mask_reg >> 1);
            mask_reg  <= mask_reg >> 1;
        end
    end

endmodule : sac_sar_core
`default_nettype wire

// >>> sac_top.sv
`timescale 1ns/1ps
`default_nettype none
module sac_top
    import sac_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic          clk_sys_i,
    input  wire logic          arst_n_i,
    // Register port
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wr_data_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    output logic      [DW-1:0] rd_data_o,
    // Power mode
    input  wire logic          standby_i,
    // Analog side
    input  wire logic          comp_i,
    output logic      [9:0]    dac_code_o,
    output logic               sample_hold_o,
    output logic               ladder_on_o,
    output logic      [5:0]    chan_en_o,
    output logic               input_gate_off_o,
    // Events
    output logic               conv_done_irq_o,
    output logic               conv_busy_o
);

    // ************************************************************
    // Registers
    // ************************************************************
    sac_state_e  state_reg;
    sac_state_e  state_next;
    logic        conv_go_reg;
    logic [1:0]  op_select_reg;
    logic        input_gate_off_reg;
    logic [3:0]  channel_sel_reg;
    logic [5:0]  ctrl_two_reg;
    logic [9:0]  result_reg;
    logic        conv_done_flag_reg;
    logic        irq_reg;
    logic [DW-1:0] rd_data_reg;

    // ************************************************************
    // Decode
    // ************************************************************
    wire        wr_one_w    = wr_i && (addr_i == ADDR_CTRL_ONE) && !standby_i;
    wire        wr_two_w    = wr_i && (addr_i == ADDR_CTRL_TWO) && !standby_i;
    wire        rd_high_w   = rd_i && (addr_i == ADDR_RES_HIGH);
    wire        busy_w      = (state_reg != S_IDLE);
    wire        op_run_w    = (op_select_reg == OP_SINGLE) || (op_select_reg == OP_REPEAT);
    wire        start_w     = conv_go_reg && op_run_w && !busy_w && !standby_i;
    wire        op_off_wr_w = wr_one_w && (wr_data_i[OP_LSB +: 2] == OP_OFF);
    wire        abort_w     = busy_w && (standby_i || op_off_wr_w);
    wire        repeat_w    = (state_reg == S_STORE) && (op_select_reg == OP_REPEAT)
                            && !abort_w;
    wire        kick_w      = start_w || repeat_w;
    wire        done_pulse_w;
    wire        step_w;
    wire        sample_w;
    wire [2:0]  ack_w       = ctrl_two_reg[ACK_LSB +: 3];
    wire        ladder_keep_on_w = ctrl_two_reg[LADDER_BIT];
    wire [9:0]  trial_w;

    wire [7:0]  ctrl_one_rd_w = {conv_go_reg, op_select_reg, input_gate_off_reg, channel_sel_reg};
    // Top two bits are undefined; they read as zero here
    wire [7:0]  ctrl_two_rd_w = {2'h0, ctrl_two_reg};
    wire [7:0]  res_high_w    = result_reg[9:2];
    // Low nibble is unstable on the part; zero keeps reads repeatable
    wire [7:0]  res_low_w     = {result_reg[1:0], conv_done_flag_reg, busy_w, 4'h0};
    wire [7:0]  rd_mux_w      = (addr_i == ADDR_CTRL_ONE) ? ctrl_one_rd_w :
                                (addr_i == ADDR_CTRL_TWO) ? ctrl_two_rd_w :
                                (addr_i == ADDR_RES_HIGH) ? res_high_w    :
                                (addr_i == ADDR_RES_LOW)  ? res_low_w     : 8'h00;

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rd_data_o        = rd_data_reg;
    assign dac_code_o       = trial_w;
    assign sample_hold_o    = sample_w;
    assign ladder_on_o      = ladder_keep_on_w || busy_w;
    assign input_gate_off_o = input_gate_off_reg;
    assign chan_en_o        = input_gate_off_reg ? 6'h00 : chan_onehot(channel_sel_reg);
    assign conv_done_irq_o  = irq_reg;
    assign conv_busy_o      = busy_w;

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (start_w) begin
                    state_next = S_CONV;
                end
            end
            S_CONV: begin
                if (abort_w) begin
                    state_next = S_IDLE;
                end else if (done_pulse_w) begin
                    state_next = S_STORE;
                end
            end
            S_STORE: begin
                state_next = repeat_w ? S_CONV : S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= S_IDLE;
        end else if (standby_i) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            conv_go_reg        <= CTRL_ONE_RESET[GO_BIT];
            op_select_reg      <= CTRL_ONE_RESET[OP_LSB +: 2];
            input_gate_off_reg <= CTRL_ONE_RESET[GATE_BIT];
            channel_sel_reg    <= CTRL_ONE_RESET[CHAN_LSB +: 4];
            ctrl_two_reg       <= CTRL_TWO_RESET;
        end else if (standby_i) begin
            conv_go_reg        <= CTRL_ONE_RESET[GO_BIT];
            op_select_reg      <= CTRL_ONE_RESET[OP_LSB +: 2];
            input_gate_off_reg <= CTRL_ONE_RESET[GATE_BIT];
            channel_sel_reg    <= CTRL_ONE_RESET[CHAN_LSB +: 4];
            ctrl_two_reg       <= CTRL_TWO_RESET;
        end else begin
            // Go lasts one cycle; with no run mode the request is dropped
            conv_go_reg <= wr_one_w ? wr_data_i[GO_BIT] : 1'b0;
            if (wr_one_w) begin
                op_select_reg      <= wr_data_i[OP_LSB +: 2];
                input_gate_off_reg <= wr_data_i[GATE_BIT];
                channel_sel_reg    <= wr_data_i[CHAN_LSB +: 4];
            end
            if (wr_two_w) begin
                ctrl_two_reg <= wr_data_i[5:0];
            end
        end
    end

    // ************************************************************
    // Result and flags
    // ************************************************************
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_reg         <= 10'h000;
            conv_done_flag_reg <= 1'b0;
            irq_reg            <= 1'b0;
        end else if (standby_i) begin
            // Earlier results are lost on standby entry
            result_reg         <= 10'h000;
            conv_done_flag_reg <= 1'b0;
            irq_reg            <= 1'b0;
        end else begin
            irq_reg <= (state_reg == S_STORE);
            if (state_reg == S_STORE) begin
                result_reg         <= trial_w;
                conv_done_flag_reg <= 1'b1;
            end else if (rd_high_w || start_w) begin
                conv_done_flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_i ? rd_mux_w : 8'h00;
        end
    end

    // ************************************************************
    // Timing and search engine
    // ************************************************************
    sac_conv_timer u_timer (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .start_i   (kick_w),
        .abort_i   (abort_w),
        .ack_i     (ack_w),
        .sample_o  (sample_w),
        .step_o    (step_w),
        .done_o    (done_pulse_w)
    );

    sac_sar_core #(
        .W (RES_W)
    ) u_sar (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .start_i   (kick_w),
        .step_i    (step_w),
        .comp_i    (comp_i),
        .trial_o   (trial_w)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_finish;
        (state_reg == S_CONV) && done_pulse_w && !abort_w ##1 (state_reg == S_STORE) && !standby_i;
    endsequence

    sequence s_published;
        conv_done_flag_reg && conv_done_irq_o && (result_reg == $past(trial_w));
    endsequence

    a_go_self_clear: assert property (conv_go_reg && !wr_one_w |=> !conv_go_reg)
        else $error("conv_go did not clear");

    a_start_busy: assert property (start_w |=> busy_w ##0 !conv_go_reg)
        else $error("start did not raise busy");

    a_store_flags: assert property (s_finish |=> s_published)
        else $error("result or done flag missing after finish");

    a_read_clears: assert property (rd_high_w && (state_reg != S_STORE) && !standby_i
                                    |=> !conv_done_flag_reg)
        else $error("done flag survived high read");

    a_standby_init: assert property (standby_i |=> !busy_w && (ctrl_one_rd_w == CTRL_ONE_RESET)
                                     && (ctrl_two_reg == CTRL_TWO_RESET))
        else $error("standby did not reinitialise");

    a_ladder_busy: assert property (ladder_on_o == (ladder_keep_on_w
                                    || (state_reg != S_IDLE)))
        else $error("ladder connection wrong");

    a_abort_nostore: assert property (abort_w && (state_reg == S_CONV)
                                      |=> (state_reg == S_IDLE) && !conv_done_irq_o)
        else $error("abort stored a result");

    a_repeat_next: assert property ((state_reg == S_STORE) && (op_select_reg == OP_REPEAT)
                                    && !standby_i && !wr_one_w |=> state_reg == S_CONV)
        else $error("repeat did not restart");

    a_high_layout: assert property (rd_high_w && (state_reg != S_STORE) && !standby_i
                                    |=> rd_data_o == result_reg[9:2])
        else $error("high result layout wrong");

    a_low_layout: assert property (rd_i && (addr_i == ADDR_RES_LOW) && !standby_i
                                   && (state_reg != S_STORE)
                                   |=> rd_data_o[7:6] == result_reg[1:0])
        else $error("low result layout wrong");

    a_chan_route: assert property (channel_sel_reg > 4'h5 |-> chan_en_o == 6'h00)
        else $error("reserved channel routed");

endmodule : sac_top
`default_nettype wire

// >>> sac_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model (
    // Clock
    input  wire logic            clk_sys_i,
    // Input levels, one per channel
    input  wire logic [5:0][9:0] level_i,
    // From the converter
    input  wire logic [5:0]      chan_en_i,
    input  wire logic            sample_hold_i,
    input  wire logic [9:0]      dac_code_i,
    // Comparator
    output logic                 comp_o
);
    logic [9:0] held = 10'h000;
    logic [9:0] pick;

    // Gated-off inputs leave the hold node low, never the last level
    always_comb begin
        pick = 10'h000;
        for (int c = 0; c < 6; c++) begin
            if (chan_en_i[c]) begin
                pick = pick | level_i[c];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sample_hold_i) begin
            held <= pick;
        end
    end

    assign comp_o = (held >= dac_code_i);
endmodule : sac_analog_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sac_pkg::*;
;
    typedef struct {
        logic [3:0] ch;
        logic [2:0] ack;
        int         t;
    } sac_row_s;

    logic            clk_sys_i = 1'b0;
    logic            arst_n_i  = 1'b0;
    logic [7:0]      addr_i    = 8'h00;
    logic [7:0]      wr_data_i = 8'h00;
    logic            wr_i      = 1'b0;
    logic            rd_i      = 1'b0;
    logic            standby_i = 1'b0;
    logic            comp;
    logic [7:0]      rd_data_o;
    logic [9:0]      dac_code_o;
    logic            sample_hold_o;
    logic            ladder_on_o;
    logic [5:0]      chan_en_o;
    logic            input_gate_off_o;
    logic            conv_done_irq_o;
    logic            conv_busy_o;
    logic [5:0][9:0] level = {10'h1FF, 10'h200, 10'h15A, 10'h2A5, 10'h000, 10'h3FF};
    int              bad_count   = 0;
    int              comparisons = 0;
    int              cycles      = 0;
    int              n;
    int              nb;
    sac_row_s        rows [8] = '{'{4'h0, 3'h0, 39}, '{4'h1, 3'h2, 78}, '{4'h2, 3'h3, 156},
        '{4'h3, 3'h4, 312}, '{4'h4, 3'h5, 624}, '{4'h5, 3'h6, 1248},
        '{4'h0, 3'h1, 1248}, '{4'h5, 3'h7, 1248}};

    sac_top i_sac_top (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .standby_i(standby_i), .comp_i(comp),
        .dac_code_o(dac_code_o), .sample_hold_o(sample_hold_o), .ladder_on_o(ladder_on_o),
        .chan_en_o(chan_en_o), .input_gate_off_o(input_gate_off_o),
        .conv_done_irq_o(conv_done_irq_o), .conv_busy_o(conv_busy_o));

    sac_analog_model i_sac_analog_model (
        .clk_sys_i(clk_sys_i), .level_i(level), .chan_en_i(chan_en_o),
        .sample_hold_i(sample_hold_o), .dac_code_i(dac_code_o), .comp_o(comp));

    // ************************************************************
    // Clock, timeout and report
    // ************************************************************
    always #25 clk_sys_i = ~clk_sys_i;

    // Whole run is near 5300 cycles, so this only trips on a hang
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // ************************************************************
    // Register bus
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_i      <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        chk(16'(rd_data_o), 16'(exp));
    endtask : rd

    // Counts busy cycles up to the done interrupt; checks the routing early on
    task automatic wait_irq(input int max, input logic [5:0] en);
        n  = 0;
        nb = 0;
        do begin
            @(posedge clk_sys_i);
            #1;
            n++;
            if (conv_busy_o === 1'b1) begin
                nb++;
            end
            if (n == 3 && en != 6'h00) begin
                chk(16'(chan_en_o), 16'(en));
                chk(16'(ladder_on_o), 16'h0001);
                chk(16'(sample_hold_o), 16'h0001);
                chk(16'(dac_code_o), 16'h0200);
            end
        end while (conv_done_irq_o !== 1'b1 && n < max);
    endtask : wait_irq

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        for (int r = 0; r < 8; r++) begin
            wr(ADDR_CTRL_TWO, {4'h1, rows[r].ack, 1'b0});
            wr(ADDR_CTRL_ONE, {4'hA, rows[r].ch});
            wait_irq(2000, 6'h01 << rows[r].ch);
            chk(16'(nb), 16'(rows[r].t + 1));
            chk(16'(conv_done_irq_o), 16'h0001);
            rd(ADDR_RES_LOW, {level[rows[r].ch][1:0], 6'h20});
            rd(ADDR_RES_HIGH, level[rows[r].ch][9:2]);
            rd(ADDR_RES_LOW, {level[rows[r].ch][1:0], 6'h00});
            rd(ADDR_CTRL_ONE, {4'h2, rows[r].ch});
        end
        // Result registers are read-only; unmapped space reads zero
        wr(ADDR_RES_HIGH, 8'h55);
        rd(ADDR_RES_HIGH, level[5][9:2]);
        rd(8'h33, 8'h00);
        wr(ADDR_CTRL_TWO, 8'hF0);
        rd(ADDR_CTRL_TWO, 8'h30);
        chk(16'(ladder_on_o), 16'h0001);
        wr(ADDR_CTRL_TWO, 8'h10);
        chk(16'(ladder_on_o), 16'h0000);
        wr(ADDR_CTRL_ONE, 8'h13);
        chk(16'({input_gate_off_o, chan_en_o}), 16'h0040);
        wr(ADDR_CTRL_ONE, 8'h03);
        chk(16'({input_gate_off_o, chan_en_o}), 16'h0008);
        wr(ADDR_CTRL_ONE, 8'h06);
        chk(16'(chan_en_o), 16'h0000);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_CTRL_ONE, {1'b1, 2'(k * 2), 5'h02});
            @(posedge clk_sys_i);
            #1;
            chk(16'(conv_busy_o), 16'h0000);
            rd(ADDR_CTRL_ONE, {1'b0, 2'(k * 2), 5'h02});
        end
        // Repeat mode, then an abort in mid-conversion
        wr(ADDR_CTRL_ONE, 8'hE2);
        wait_irq(200, 6'h04);
        chk(16'(conv_busy_o), 16'h0001);
        rd(ADDR_RES_HIGH, level[2][9:2]);
        wait_irq(200, 6'h00);
        chk(16'({conv_done_irq_o, conv_busy_o}), 16'h0003);
        wr(ADDR_CTRL_ONE, 8'h02);
        @(posedge clk_sys_i);
        #1;
        chk(16'(conv_busy_o), 16'h0000);
        wait_irq(100, 6'h00);
        chk(16'(n), 16'd100);
        // Standby entry during a long conversion
        wr(ADDR_CTRL_TWO, 8'h1C);
        wr(ADDR_CTRL_ONE, 8'hA1);
        repeat (10) @(posedge clk_sys_i);
        standby_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        chk(16'(conv_busy_o), 16'h0000);
        wr(ADDR_CTRL_ONE, 8'hA3);
        rd(ADDR_CTRL_ONE, 8'h10);
        rd(ADDR_CTRL_TWO, 8'h10);
        rd(ADDR_RES_HIGH, 8'h00);
        @(posedge clk_sys_i);
        standby_i <= 1'b0;
        // Second reset in mid-run
        wr(ADDR_CTRL_TWO, 8'h30);
        wr(ADDR_CTRL_ONE, 8'hA3);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk(16'(conv_busy_o), 16'h0001);
        @(posedge clk_sys_i);
        arst_n_i <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        #1;
        chk(16'({input_gate_off_o, chan_en_o}), 16'h0040);
        chk(16'({dac_code_o, ladder_on_o, conv_busy_o}), 16'h0000);
        rd(ADDR_CTRL_ONE, 8'h10);
        rd(ADDR_CTRL_TWO, 8'h10);
        rd(ADDR_RES_LOW, 8'h00);
        rd(ADDR_RES_HIGH, 8'h00);
        test_done();
    end
endmodule : testbench
`default_nettype wire
